// [core/adc_config_and_result_regs.sv]
// configuration, sequencing and result registers of the converter
`timescale 1ns/1ps
module adc_config_and_result_regs #(
  parameter logic [15:0] CRC_POLY = 16'h8005
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // register port behind the serial command decoder
  input  wire logic                  wr_en,
  input  wire logic [3:0]            wr_addr,
  input  wire logic [7:0]            wr_data,
  input  wire logic                  rd_start,
  input  wire logic [3:0]            rd_addr,
  output logic                       rd_valid,
  output logic [31:0]                rd_data,
  output logic [5:0]                 rd_bits,
  output logic [15:0]                rd_crc,
  output logic                       rd_crc_attach,
  output logic                       rd_crc_wide,
  // filtered conversions from the decimator
  input  wire logic                  sample_valid,
  input  wire adc_regs_pkg::sample_t sample_in,
  output logic                       sample_ready,
  // calibration values from their own registers
  input  wire logic [23:0]           offset_cal,
  input  wire logic [23:0]           gain_cal,
  // modulator output and interrupt pin sharing
  input  wire logic                  modulator_stream_select,
  input  wire logic [3:0]            mod_comp,
  input  wire logic                  mod_stream_bit,
  input  wire logic                  por_irq,
  input  wire logic                  crc_irq,
  input  wire logic                  irq_n_in,
  output logic                       irq_pin,
  // analog and clock controls
  output logic                       int_osc_select,
  output logic                       clk_out_enable,
  output logic                       analog_master_clock_tick,
  output logic [1:0]                 bias_code,
  output logic [1:0]                 boost_code,
  output logic [2:0]                 analog_gain_code,
  output logic [1:0]                 digital_gain_shift,
  output logic                       auto_zero_enable,
  output logic                       full_shutdown,
  output logic                       adc_standby,
  // conversion sequencing
  output logic                       conv_start,
  output logic                       conv_active,
  output logic                       conv_done,
  output logic                       data_ready
);

  logic [7:0]  cfg0_q;
  logic [7:0]  cfg1_q;
  logic [7:0]  cfg2_q;
  logic [7:0]  cfg3_q;
  logic [1:0]  adc_mode;
  logic [1:0]  run_mode;
  logic [1:0]  out_fmt;
  logic [2:0]  gain_code;
  logic [2:0]  div_cnt_q;
  logic [2:0]  div_mask;
  adc_regs_pkg::seq_state_t state_q;
  logic [17:0] conv_cnt_q;
  logic [17:0] conv_target;
  logic        done_now;
  logic        conv_start_q;
  logic        conv_done_q;
  logic        fifo_valid;
  adc_regs_pkg::sample_t fifo_data;
  logic        fifo_ready;
  logic [4:0]  gap_cnt_q;
  logic        s1_valid_q;
  logic [3:0]  s1_channel_identifier_q;
  logic [25:0] s1_sum_q;
  logic [24:0] result_q;
  logic [3:0]  result_channel_identifier_q;
  logic        data_ready_q;
  logic [3:0]  modulator_stream_q;
  logic        rd_valid_q;
  logic [31:0] rd_data_q;
  logic [5:0]  rd_bits_q;
  logic [15:0] rd_crc_q;
  logic [31:0] rd_word;
  logic [5:0]  rd_len;

  // sign-extend then saturate a scaled value back into 25 bits
  function automatic logic [24:0] scale_gain(input logic [25:0] sum,
                                             input logic [23:0] gain);
    logic signed [50:0] prod;
    logic signed [50:0] shifted;
    prod    = 51'(signed'(sum)) * signed'({27'h0, gain});
    shifted = prod >>> adc_regs_pkg::GAIN_FRAC;
    if (shifted > 51'sh0ffffff) begin
      scale_gain = 25'h0ffffff;
    end else if (shifted < -51'sh1000000) begin
      scale_gain = 25'h1000000;
    end else begin
      scale_gain = shifted[24:0];
    end
  endfunction : scale_gain

  // lock an overrange value to the full-scale codes
  function automatic logic [23:0] clamp24(input logic [24:0] v);
    if (v[24] == v[23]) begin
      clamp24 = v[23:0];
    end else if (!v[24]) begin
      clamp24 = adc_regs_pkg::CLAMP_POS;
    end else begin
      clamp24 = adc_regs_pkg::CLAMP_NEG;
    end
  endfunction : clamp24

  // checksum over the low nbits of the read word, msb first
  function automatic logic [15:0] crc16(input logic [31:0] word,
                                        input logic [5:0]  nbits);
    logic [15:0] c;
    logic        fb;
    c = '0;
    for (int i = 31; i >= 0; i--) begin
      if (i < int'(nbits)) begin
        fb = c[15] ^ word[i];
        c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
    end
    crc16 = c;
  endfunction : crc16

  // field views of the configuration bytes
  assign adc_mode  = cfg0_q[adc_regs_pkg::MODE_LSB +: 2];
  assign run_mode  = cfg3_q[adc_regs_pkg::RUN_LSB +: 2];
  assign out_fmt   = cfg3_q[adc_regs_pkg::FMT_LSB +: 2];
  assign gain_code = cfg2_q[adc_regs_pkg::GAIN_LSB +: 3];

  // decoded analog controls
  assign int_osc_select =
    cfg0_q[adc_regs_pkg::CLKSEL_LSB + 1];
  assign clk_out_enable = (cfg0_q[adc_regs_pkg::CLKSEL_LSB +: 2] ==
                           adc_regs_pkg::CLK_INT_OUT);
  assign bias_code  = cfg0_q[adc_regs_pkg::BIAS_LSB +: 2];
  assign boost_code = cfg2_q[adc_regs_pkg::BOOST_LSB +: 2];
  // top two gain codes run the analog stage at x16 and shift digitally
  assign analog_gain_code   = (gain_code[2] && gain_code[1]) ?
                              3'h5 : gain_code;
  assign digital_gain_shift = (gain_code == 3'h7) ? 2'h2 :
                              (gain_code == 3'h6) ? 2'h1 : 2'h0;
  assign auto_zero_enable = cfg2_q[adc_regs_pkg::AZ_BIT];
  assign full_shutdown = (cfg0_q == adc_regs_pkg::CFG0_FULL_OFF);
  assign adc_standby   = (adc_mode == adc_regs_pkg::MODE_STBY);

  // configuration bytes; the end-of-conversion mode change wins over a write
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg0_q <= adc_regs_pkg::CFG0_RST;
      cfg1_q <= adc_regs_pkg::CFG1_RST;
      cfg2_q <= adc_regs_pkg::CFG2_RST;
      cfg3_q <= adc_regs_pkg::CFG3_RST;
    end else begin
      if (wr_en) begin
        unique case (wr_addr)
          adc_regs_pkg::ADDR_CFG0: cfg0_q <= wr_data;
          adc_regs_pkg::ADDR_CFG1: cfg1_q <= wr_data;
          adc_regs_pkg::ADDR_CFG2: cfg2_q <= wr_data;
          adc_regs_pkg::ADDR_CFG3: cfg3_q <= wr_data;
          default: ;  // result register and unmapped: ignored
        endcase
      end
      if (done_now && run_mode != adc_regs_pkg::RUN_CONT) begin
        cfg0_q[adc_regs_pkg::MODE_LSB +: 2] <=
          (run_mode == adc_regs_pkg::RUN_ONE_STBY) ?
          adc_regs_pkg::MODE_STBY : adc_regs_pkg::MODE_SHDN;
      end
    end
  end

  // prescaler: a tick every 1, 2, 4 or 8 master clocks
  assign div_mask = 3'((4'h1 << cfg1_q[adc_regs_pkg::PRE_LSB +: 2]) - 4'h1);
  assign analog_master_clock_tick = ((div_cnt_q & div_mask) == div_mask);

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end

  // conversion length in analog clock ticks, doubled by auto-zeroing
  assign conv_target = auto_zero_enable ?
    {adc_regs_pkg::osr_ratio(cfg1_q[adc_regs_pkg::OSR_LSB +: 4]), 1'b0} :
    {1'b0, adc_regs_pkg::osr_ratio(cfg1_q[adc_regs_pkg::OSR_LSB +: 4])};
  assign done_now = (state_q == adc_regs_pkg::SEQ_RUN) &&
                    (adc_mode == adc_regs_pkg::MODE_CONV) &&
                    analog_master_clock_tick && (conv_cnt_q == 18'h00001);

  // sequencer: a start pulse opens a conversion from idle, done closes it; continuous runs without auto-zero reload at done with no new start
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q      <= adc_regs_pkg::SEQ_IDLE;
      conv_cnt_q   <= '0;
      conv_start_q <= 1'b0;
      conv_done_q  <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      conv_done_q  <= done_now;
      unique case (state_q)
        adc_regs_pkg::SEQ_IDLE: begin
          if (adc_mode == adc_regs_pkg::MODE_CONV) begin
            conv_start_q <= 1'b1;
            conv_cnt_q   <= conv_target;
            state_q      <= adc_regs_pkg::SEQ_RUN;
          end
        end
        adc_regs_pkg::SEQ_RUN: begin
          if (adc_mode != adc_regs_pkg::MODE_CONV) begin
            state_q <= adc_regs_pkg::SEQ_IDLE;
          end else if (done_now) begin
            // auto-zero falls back to a fresh start for every conversion
            if (run_mode == adc_regs_pkg::RUN_CONT &&
                !auto_zero_enable) begin
              conv_cnt_q <= conv_target;
            end else begin
              state_q <= adc_regs_pkg::SEQ_IDLE;
            end
          end else if (analog_master_clock_tick) begin
            conv_cnt_q <= conv_cnt_q - 18'h00001;
          end
        end
      endcase
    end
  end

  assign conv_start  = conv_start_q;
  assign conv_active = (state_q == adc_regs_pkg::SEQ_RUN);
  assign conv_done   = conv_done_q;

  // input buffer absorbs bursts while refreshes are spaced out
  sample_fifo #(
    .WIDTH ($bits(adc_regs_pkg::sample_t)),
    .DEPTH (4)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (sample_valid),
    .in_data   (sample_in),
    .in_ready  (sample_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_ready)
  );

  // drain only once the previous refresh has settled
  assign fifo_ready = (gap_cnt_q == '0);

  always_ff @(posedge clk) begin
    if (rst) begin
      gap_cnt_q <= '0;
    end else if (fifo_valid && fifo_ready) begin
      gap_cnt_q <= 5'(adc_regs_pkg::RESULT_GAP_CYC);
    end else if (gap_cnt_q != '0) begin
      gap_cnt_q <= gap_cnt_q - 5'h01;
    end
  end

  // first stage: optional offset correction
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_valid_q <= 1'b0;
      s1_channel_identifier_q  <= '0;
      s1_sum_q   <= '0;
    end else begin
      s1_valid_q <= fifo_valid && fifo_ready;
      if (fifo_valid && fifo_ready) begin
        s1_channel_identifier_q <= fifo_data.channel_identifier;
        s1_sum_q  <= {fifo_data.value[24], fifo_data.value} +
                     (cfg3_q[adc_regs_pkg::OFFEN_BIT] ?
                      {{2{offset_cal[23]}}, offset_cal} : 26'h0);
      end
    end
  end

  // second stage: optional gain correction into the result register
  always_ff @(posedge clk) begin
    if (rst) begin
      result_q      <= '0;
      result_channel_identifier_q <= '0;
      data_ready_q  <= 1'b0;
    end else begin
      data_ready_q <= s1_valid_q;
      if (s1_valid_q) begin
        result_channel_identifier_q <= s1_channel_identifier_q;
        if (cfg3_q[adc_regs_pkg::GAINEN_BIT]) begin
          result_q <= scale_gain(s1_sum_q, gain_cal);
        end else if (s1_sum_q[25] != s1_sum_q[24]) begin
          result_q <= s1_sum_q[25] ? 25'h1000000 : 25'h0ffffff;
        end else begin
          result_q <= s1_sum_q[24:0];
        end
      end
    end
  end

  assign data_ready = data_ready_q;

  // comparator bits kept for the modulator view of the result
  always_ff @(posedge clk) begin
    if (rst) begin
      modulator_stream_q <= '0;
    end else begin
      modulator_stream_q <= mod_comp;
    end
  end

  // word that a read at rd_addr would return now
  always_comb begin
    rd_word = '0;
    rd_len  = adc_regs_pkg::BITS_REG;
    unique case (rd_addr)
      adc_regs_pkg::ADDR_RESULT: begin
        if (modulator_stream_select) begin
          rd_word = {28'h0, modulator_stream_q};
          rd_len  = adc_regs_pkg::BITS_MODULATOR_STREAM;
        end else begin
          rd_len = adc_regs_pkg::BITS_32;
          unique case (out_fmt)
            adc_regs_pkg::FMT_CHANNEL_IDENTIFIER:
              rd_word = {result_channel_identifier_q, {4{result_q[24]}},
                         result_q[23:0]};
            adc_regs_pkg::FMT_SGN32:
              rd_word = {{8{result_q[24]}}, result_q[23:0]};
            adc_regs_pkg::FMT_LEFT32:
              rd_word = {clamp24(result_q), 8'h00};
            default: begin
              rd_word = {8'h00, clamp24(result_q)};
              rd_len  = adc_regs_pkg::BITS_24;
            end
          endcase
        end
      end
      adc_regs_pkg::ADDR_CFG0: rd_word = {24'h0, cfg0_q};
      adc_regs_pkg::ADDR_CFG1: rd_word = {24'h0, cfg1_q};
      adc_regs_pkg::ADDR_CFG2: rd_word = {24'h0, cfg2_q};
      adc_regs_pkg::ADDR_CFG3: rd_word = {24'h0, cfg3_q};
      default: rd_word = '0;
    endcase
  end

  // read buffer: frozen at read start so a refresh cannot tear the word
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= '0;
      rd_bits_q  <= '0;
      rd_crc_q   <= '0;
    end else begin
      rd_valid_q <= rd_start;
      if (rd_start) begin
        rd_data_q <= rd_word;
        rd_bits_q <= rd_len;
        rd_crc_q  <= crc16(rd_word, rd_len);
      end
    end
  end

  assign rd_valid      = rd_valid_q;
  assign rd_data       = rd_data_q;
  assign rd_bits       = rd_bits_q;
  assign rd_crc        = rd_crc_q;
  assign rd_crc_attach = cfg3_q[adc_regs_pkg::CRCEN_BIT];
  assign rd_crc_wide   = cfg3_q[adc_regs_pkg::CRCW_BIT];

  // pin sharing: power and checksum interrupts pull low over the stream
  assign irq_pin = !modulator_stream_select ? irq_n_in :
                   (por_irq || crc_irq) ? 1'b0 : mod_stream_bit;

endmodule : adc_config_and_result_regs

// [core/adc_regs_pkg.sv]
// shared constants, types and helpers of the converter register block
package adc_regs_pkg;

  // register addresses
  localparam logic [3:0] ADDR_RESULT = 4'h0;
  localparam logic [3:0] ADDR_CFG0   = 4'h1;
  localparam logic [3:0] ADDR_CFG1   = 4'h2;
  localparam logic [3:0] ADDR_CFG2   = 4'h3;
  localparam logic [3:0] ADDR_CFG3   = 4'h4;

  // reset values of the configuration registers
  localparam logic [7:0] CFG0_RST = 8'hc0;
  localparam logic [7:0] CFG1_RST = 8'h0c;
  localparam logic [7:0] CFG2_RST = 8'h8b;
  localparam logic [7:0] CFG3_RST = 8'h00;

  // field positions (lsb of each field)
  localparam int MODE_LSB    = 0;  // clock_bias_state_config
  localparam int BIAS_LSB    = 2;
  localparam int CLKSEL_LSB  = 4;
  localparam int PRE_LSB     = 6;  // prescale_oversample_config
  localparam int OSR_LSB     = 2;
  localparam int AZ_BIT      = 2;  // boost_gain_autozero_config
  localparam int GAIN_LSB    = 3;
  localparam int BOOST_LSB   = 6;
  localparam int GAINEN_BIT  = 0;  // conversion_format_config
  localparam int OFFEN_BIT   = 1;
  localparam int CRCEN_BIT   = 2;
  localparam int CRCW_BIT    = 3;
  localparam int FMT_LSB     = 4;
  localparam int RUN_LSB     = 6;

  // field codes
  localparam logic [1:0] MODE_CONV   = 2'b11;
  localparam logic [1:0] MODE_STBY   = 2'b10;
  localparam logic [1:0] MODE_SHDN   = 2'b00;
  localparam logic [1:0] CLK_INT_OUT = 2'b11;
  localparam logic [1:0] CLK_INT     = 2'b10;
  localparam logic [1:0] RUN_CONT    = 2'b11;
  localparam logic [1:0] RUN_ONE_STBY = 2'b10;
  localparam logic [1:0] FMT_CHANNEL_IDENTIFIER    = 2'b11;
  localparam logic [1:0] FMT_SGN32   = 2'b10;
  localparam logic [1:0] FMT_LEFT32  = 2'b01;
  localparam logic [7:0] CFG0_FULL_OFF = 8'h00;

  // clamp codes and read lengths
  localparam logic [23:0] CLAMP_POS = 24'hffffff;
  localparam logic [23:0] CLAMP_NEG = 24'h800000;
  localparam logic [5:0]  BITS_MODULATOR_STREAM = 6'h04;
  localparam logic [5:0]  BITS_REG  = 6'h08;
  localparam logic [5:0]  BITS_24   = 6'h18;
  localparam logic [5:0]  BITS_32   = 6'h20;
  localparam int          GAIN_FRAC = 23;   // gain code 0x800000 is unity

  // spacing between two result refreshes
  localparam int CLK_PERIOD_NS  = 10;
  localparam int RESULT_GAP_NS  = 100;
  localparam int RESULT_GAP_CYC =
    (RESULT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // conversion sequencer states
  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN  = 1'b1
  } seq_state_t;

  // one filtered conversion, 25-bit signed to allow overrange
  typedef struct packed {
    logic [3:0]  channel_identifier;
    logic [24:0] value;
  } sample_t;

  // oversampling ratio per code
  function automatic logic [16:0] osr_ratio(input logic [3:0] code);
    unique case (code)
      4'h0: osr_ratio = 17'd32;
      4'h1: osr_ratio = 17'd64;
      4'h2: osr_ratio = 17'd128;
      4'h3: osr_ratio = 17'd256;
      4'h4: osr_ratio = 17'd512;
      4'h5: osr_ratio = 17'd1024;
      4'h6: osr_ratio = 17'd2048;
      4'h7: osr_ratio = 17'd4096;
      4'h8: osr_ratio = 17'd8192;
      4'h9: osr_ratio = 17'd16384;
      4'ha: osr_ratio = 17'd20480;
      4'hb: osr_ratio = 17'd24576;
      4'hc: osr_ratio = 17'd40960;
      4'hd: osr_ratio = 17'd49152;
      4'he: osr_ratio = 17'd81920;
      4'hf: osr_ratio = 17'd98304;
    endcase
  endfunction : osr_ratio

endpackage : adc_regs_pkg

// [core/sample_fifo.sv]
// small synchronous fifo with a registered output word
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 29,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  logic             push;
  logic             pop;

  // the output register takes a stored word whenever one is held and it is empty or being drained
  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign push      = in_valid && in_ready;
  assign pop       = (count_q != '0) && (!out_valid_q || out_ready);
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;

  // storage writes
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // registered read word
  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else if (pop) begin
      out_valid_q <= 1'b1;
      out_data_q  <= mem_q[rd_ptr_q];
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end

endmodule : sample_fifo

// [verification/adc_regs_assertions.sv]
// port checker for the converter register block
`timescale 1ns/1ps
module adc_regs_assertions (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // register port
  input wire logic       wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic       rd_start,
  input wire logic [3:0] rd_addr,
  input wire logic       rd_valid,
  input wire logic [5:0] rd_bits,
  input wire logic       rd_crc_attach,
  // pins and decoded controls
  input wire logic       modulator_stream_select,
  input wire logic       por_irq,
  input wire logic       irq_pin,
  input wire logic       int_osc_select,
  input wire logic       clk_out_enable,
  input wire logic       full_shutdown,
  input wire logic       adc_standby,
  input wire logic       data_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rd_valid; rd_start |=> rd_valid; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("no answer");
  property p_modulator_stream_bits;
    rd_start && rd_addr == 4'h0 && modulator_stream_select |=> rd_bits == 6'h04;
  endproperty
  a_modulator_stream_bits: assert property (p_modulator_stream_bits) else $error("bad bits");
  property p_clk_out;
    wr_en && wr_addr == 4'h1 |=> {int_osc_select, clk_out_enable} ==
      {$past(wr_data[5]), $past(wr_data[5:4]) == 2'b11};
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("bad clock");
  property p_shdn;
    wr_en && wr_addr == 4'h1 |=> full_shutdown == ($past(wr_data) == 8'h00);
  endproperty
  a_shdn: assert property (p_shdn) else $error("bad shutdown");
  property p_stby;
    wr_en && wr_addr == 4'h1 && wr_data[1:0] == 2'b10 |=> adc_standby;
  endproperty
  a_stby: assert property (p_stby) else $error("no standby");
  property p_irq; modulator_stream_select && por_irq |-> !irq_pin; endproperty
  a_irq: assert property (p_irq) else $error("irq not forced");
  property p_refresh; data_ready |=> !data_ready [*8]; endproperty
  a_refresh: assert property (p_refresh) else $error("refresh gap");
  property p_crc;
    wr_en && wr_addr == 4'h4 |=> rd_crc_attach == $past(wr_data[2]);
  endproperty
  a_crc: assert property (p_crc) else $error("bad crc enable");
endmodule : adc_regs_assertions
bind adc_config_and_result_regs adc_regs_assertions chk_u (.*);

// [verification/host_model.sv]
// host side of the register port: byte writes and read commands
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic        clk,
  // register port
  output logic             wr_en = 1'b0,
  output logic [3:0]       wr_addr = 4'h0,
  output logic [7:0]       wr_data = 8'h00,
  output logic             rd_start = 1'b0,
  output logic [3:0]       rd_addr = 4'h0,
  input  wire logic [31:0] rd_data,
  input  wire logic [5:0]  rd_bits
);
  // data line shows the inverse after release, never a stale byte
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= v;
    @(posedge clk);
    wr_en <= 1'b0;
    wr_data <= ~v;
  endtask : wr
  // answer is taken one cycle after the command edge
  task automatic rd(input logic [3:0] a, output logic [31:0] v,
                    output logic [5:0] n);
    @(posedge clk);
    rd_start <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_start <= 1'b0;
    #1;
    v = rd_data;
    n = rd_bits;
  endtask : rd
endmodule : host_model

// [verification/adc_config_and_result_regs_bench.sv]
// self-checking bench for the converter register block
`timescale 1ns/1ps
module adc_config_and_result_regs_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en, rd_start, conv_done, sample_valid = 1'b0;
  logic [3:0] wr_addr, rd_addr, mod_comp = 4'h0;
  logic [7:0] wr_data;
  logic [31:0] rd_data, d;
  logic [5:0] rd_bits, n;
  adc_regs_pkg::sample_t sample_in = '0;
  logic [23:0] offset_cal = 24'h000000, gain_cal = 24'h800000;
  logic modulator_stream_select = 1'b0, por_irq = 1'b0, crc_irq = 1'b0;
  logic irq_n_in = 1'b1, mod_stream_bit = 1'b1;
  logic rd_valid, rd_crc_wide, analog_master_clock_tick, full_shutdown, adc_standby;
  logic [1:0] bias_code, boost_code, digital_gain_shift;
  logic [2:0] analog_gain_code;
  int n_mismatch = 0, checked = 0;
  int k;
  logic [39:0] rst_vals = 40'h00c00c8b00;
  logic [19:0] cfg_rows [5] = '{20'h13636, 20'h20000, 20'h3f7f7,
                                20'h40c0c, 20'h5ff00};
  logic [39:0] fmt_rows [4] = '{40'h2000800000, 40'h0000ffffff,
                                40'h3050800000, 40'h10ffffff00};
  always #5 clk = ~clk;
  host_model host_u (.*);
  adc_config_and_result_regs dut_u (.*, .rd_crc(),
    .rd_crc_attach(), .sample_ready(), .irq_pin(),
    .int_osc_select(), .clk_out_enable(), .auto_zero_enable(),
    .conv_start(), .conv_active(), .data_ready());
  task automatic chk(input string s, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h got %h", s, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // one sample into an empty fifo lands in the result three edges after the fifo takes it
  task automatic push(input logic [24:0] v);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_in <= {4'h5, v};
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : push
  initial begin
    #200000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      host_u.rd(4'(i), d, n);
      chk("reset value", {24'h0, rst_vals[39-8*i -: 8]}, d);
    end
    $display("test reset done");
    foreach (cfg_rows[i]) begin
      host_u.wr(cfg_rows[i][19:16], cfg_rows[i][15:8]);
      host_u.rd(cfg_rows[i][19:16], d, n);
      chk("readback", {24'h0, cfg_rows[i][7:0]}, d);
    end
    // rows left bias 01, boost 11, gain 110 and the wide checksum set
    chk("bias code", 32'h1, bias_code);
    chk("boost code", 32'h3, boost_code);
    chk("analog gain", 32'h5, analog_gain_code);
    chk("digital gain", 32'h1, digital_gain_shift);
    chk("checksum wide", 32'h1, rd_crc_wide);
    $display("test registers done");
    push(25'h0800000);
    foreach (fmt_rows[i]) begin
      host_u.wr(4'h4, fmt_rows[i][39:32]);
      host_u.rd(4'h0, d, n);
      chk("format word", fmt_rows[i][31:0], d);
    end
    offset_cal <= 24'h000010;
    host_u.wr(4'h4, 8'h22);
    push(25'h0000100);
    host_u.rd(4'h0, d, n);
    chk("offset corrected", 32'h00000110, d);
    // half-scale gain code halves the sample, offset now disabled
    gain_cal <= 24'h400000;
    host_u.wr(4'h4, 8'h21);
    push(25'h0000100);
    host_u.rd(4'h0, d, n);
    chk("gain corrected", 32'h00000080, d);
    $display("test result path done");
    // divide by eight: two analog ticks in any sixteen clocks
    host_u.wr(4'h2, 8'hc0);
    k = 0;
    repeat (16) begin
      @(posedge clk) #1;
      k += analog_master_clock_tick;
    end
    chk("ticks per 16 clocks", 32'h2, k);
    $display("test prescaler done");
    // ratio 32 doubled by auto-zero: done shows 65 edges after the write
    host_u.wr(4'h2, 8'h00);
    for (int i = 0; i < 2; i++) begin
      host_u.wr(4'h4, i ? 8'h00 : 8'h80);
      host_u.wr(4'h1, 8'h03);
      for (k = 0; k < 99 && conv_done !== 1'b1; k++) @(posedge clk) #1;
      chk("one shot length", 32'h41, k);
      host_u.rd(4'h1, d, n);
      chk("mode after one shot", i ? 32'h0 : 32'h2, d);
      chk("full shutdown", i, full_shutdown);
      chk("standby", 1 - i, adc_standby);
    end
    $display("test one shot done");
    modulator_stream_select <= 1'b1;
    mod_comp <= 4'h9;
    por_irq <= 1'b1;
    host_u.rd(4'h0, d, n);
    chk("modulator bits", 32'h9, d);
    chk("modulator count", 32'h4, {26'h0, n});
    chk("read valid", 32'h1, rd_valid);
    $display("test modulator done");
    print_verdict;
  end
endmodule : adc_config_and_result_regs_bench
